// [common/rss_pkg.sv]
// Package for the relay scan sequencer: register map, field layout,
// reset values, state codes and timing counts.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package rss_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Relay settle time before a closure counts as done, and trigger pulse width.
  localparam int SETTLE_NS = 100;
  localparam int PULSE_NS = 200;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W = 8;
  localparam int LIST_DEPTH = 16;
  localparam int NUM_BP_LINES = 8;
  localparam int MAT_ROWS = 16;
  localparam int MAT_COLS = 16;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OUTST = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_BPTRIG = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_ARMCNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CARD = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_LISTLEN = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_LIST_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_MON_BASE = 8'h80;

  // Control register fields.
  localparam int CTRL_CONT = 0;
  localparam int CTRL_MON = 1;
  localparam int CTRL_EXT = 2;
  localparam int CTRL_AUTO = 3;
  // Command register fields.
  localparam int CMD_START = 0;
  localparam int CMD_TRIG = 1;
  localparam int CMD_RESET = 2;
  // Backplane trigger select fields.
  localparam int BP_EN = 3;
  // Interrupt status bits.
  localparam int IRQ_CLOSE = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_W = 3;

  localparam logic [14:0] ARMCNT_RST = 15'h0001;
  localparam logic [6:0] CARD_MAX = 7'h63;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RSS_IDLE = 2'b00,
    RSS_SETTLE = 2'b01,
    RSS_WAIT = 2'b10
  } rss_state_t;

endpackage

// [core/rss_core.sv]
// Relay scan sequencer core: channel list scanning, trigger output gating,
// channel monitor and AXI4-Lite register slave.
// Assumes one 100 MHz clock; trig_i is asynchronous and is synchronised here.
`timescale 1ns/1ps
`default_nettype none

module rss_core
  import rss_pkg::*;
(
  input wire logic clk_i, // 100 MHz clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic trig_i, // Async scan advance trigger
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic chan_closed_o, // A channel relay is closed
  output logic [6:0] chan_card_o, // Card of closed channel
  output logic [3:0] chan_row_o, // Row of closed channel
  output logic [3:0] chan_col_o, // Column of closed channel
  output logic ext_trig_n_o, // External trigger out, active low
  output logic ext_trig_oe_o, // External trigger drive enable
  output logic [NUM_BP_LINES-1:0] bp_trig_n_o, // Backplane lines, active low
  output logic [NUM_BP_LINES-1:0] bp_trig_oe_o, // Backplane drive enables
  output logic mon_on_o, // Monitor display active
  output logic [6:0] mon_card_o, // Card being monitored
  output logic [3:0] mon_row_o, // Row label of displayed bitmap
  output logic [15:0] mon_bits_o, // Row bitmap, bit per column
  output logic irq_o // Level interrupt
);

  // Configuration registers.
  logic cont_q, mon_q, ext_en_q, auto_q, bp_en_q;
  logic [2:0] bp_sel_q;
  logic [14:0] armcnt_q;
  logic [6:0] card_q;
  logic [4:0] list_len_q;
  logic [14:0] list_q [LIST_DEPTH];
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
  logic start_q, trig_cmd_q, rst_cmd_q;

  // Scanner state.
  rss_state_t state_q;
  logic closed_q;
  logic [3:0] list_idx_q;
  logic [14:0] cycles_q;
  logic [7:0] settle_cnt_q, pulse_cnt_q;
  logic [6:0] cur_card_q, last_card_q;
  logic [3:0] cur_row_q, cur_col_q;
  logic [3:0] mon_cnt_q;
  logic trig_meta_q, trig_sync_q, trig_prev_q;

  // AXI slave state. The ready flops are low while an item is held.
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  function automatic logic [15:0] row_bits(input logic [3:0] r,
    input logic cl, input logic [6:0] cc, input logic [6:0] mc,
    input logic [3:0] cr, input logic [3:0] ccol);
    row_bits = (cl && cc == mc && cr == r) ? (16'h0001 << ccol) : 16'h0000;
  endfunction

  function automatic logic card_ok(input logic [6:0] c);
    card_ok = (c != 7'h00) && (c <= CARD_MAX);
  endfunction

  // List validity: non-empty, fits the store, and every card number legal.
  logic list_ok;
  always_comb
  begin
    list_ok = (list_len_q != 5'h00) && (list_len_q <= 5'(LIST_DEPTH));
    for (int i = 0; i < LIST_DEPTH; i++)
    begin
      if (5'(i) < list_len_q && !card_ok(list_q[i][14:8]))
        list_ok = 1'b0;
    end
  end

  wire [6:0] mon_card_w = auto_q ? last_card_q : card_q;
  wire trig_edge_w = trig_sync_q & ~trig_prev_q;
  wire advance_w = (state_q == RSS_WAIT) && (trig_edge_w || trig_cmd_q);
  wire last_entry_w = ({1'b0, list_idx_q} == list_len_q - 5'h01);
  wire start_go_w = start_q && (state_q == RSS_IDLE) && list_ok;
  wire settle_done_w = (state_q == RSS_SETTLE) && (settle_cnt_q == 8'h01);
  wire [14:0] next_entry_w = last_entry_w ? list_q[0] : list_q[list_idx_q + 4'h1];

  // Write path: a write is done once both address and data are held.
  wire wr_go_w = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [31:0] wmask_w = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
    {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wd_w = wdata_q & wmask_w;
  wire wr_list_w = awaddr_q[7:6] == 2'b01;
  wire wr_known_w = wr_list_w || awaddr_q <= OFF_IRQ_MASK;
  wire [31:0] ctrl_rd_w = {28'h0, auto_q, ext_en_q, mon_q, cont_q};

  // Read decode.
  wire [ADDR_W-1:0] ra_w = s_axi_araddr;
  wire [3:0] rrow_w = ra_w[5:2];
  wire rd_list_w = ra_w[7:6] == 2'b01;
  wire rd_mon_w = ra_w[7:6] == 2'b10;
  wire [15:0] rd_bits_w = row_bits(rrow_w, closed_q, cur_card_q,
    mon_card_w, cur_row_q, cur_col_q);
  wire rd_known_w = rd_list_w || rd_mon_w || ra_w <= OFF_IRQ_MASK;
  wire [31:0] rd_w =
    (ra_w == OFF_CTRL) ? ctrl_rd_w :
    (ra_w == OFF_OUTST) ? {31'h0, ext_en_q} :
    (ra_w == OFF_BPTRIG) ? {28'h0, bp_en_q, bp_sel_q} :
    (ra_w == OFF_ARMCNT) ? {17'h0, armcnt_q} :
    (ra_w == OFF_CARD) ? {25'h0, card_q} :
    (ra_w == OFF_LISTLEN) ? {27'h0, list_len_q} :
    (ra_w == OFF_STATUS) ? {26'h0, list_idx_q, closed_q, state_q != RSS_IDLE} :
    (ra_w == OFF_IRQ_STAT) ? {29'h0, irq_stat_q} :
    (ra_w == OFF_IRQ_MASK) ? {29'h0, irq_mask_q} :
    rd_list_w ? {17'h0, list_q[ra_w[5:2]]} :
    (rd_mon_w && mon_q) ? {12'h0, rrow_w, rd_bits_w} : 32'h0;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go_w)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known_w ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
        s_axi_rdata <= rd_w;
        s_axi_rresp <= rd_known_w ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Register file. Commands are one-cycle pulses to the scanner.
  wire [IRQ_W-1:0] irq_set_w = {start_q && state_q == RSS_IDLE && !list_ok,
    (state_q == RSS_WAIT) && advance_w && last_entry_w && !cont_q &&
    cycles_q <= 15'h0001, settle_done_w};
  wire [IRQ_W-1:0] irq_clr_w = (wr_go_w && awaddr_q == OFF_IRQ_STAT) ?
    wd_w[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cont_q <= 1'b0;
      mon_q <= 1'b0;
      ext_en_q <= 1'b0;
      auto_q <= 1'b1;
      bp_en_q <= 1'b0;
      bp_sel_q <= 3'h0;
      armcnt_q <= ARMCNT_RST;
      card_q <= 7'h01;
      list_len_q <= 5'h00;
      for (int i = 0; i < LIST_DEPTH; i++)
        list_q[i] <= 15'h0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      start_q <= 1'b0;
      trig_cmd_q <= 1'b0;
      rst_cmd_q <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle.
      irq_stat_q <= (irq_stat_q & ~irq_clr_w) | irq_set_w;
      start_q <= 1'b0;
      trig_cmd_q <= 1'b0;
      rst_cmd_q <= 1'b0;
      if (wr_go_w)
      begin
        if (awaddr_q == OFF_CMD)
        begin
          start_q <= wd_w[CMD_START];
          trig_cmd_q <= wd_w[CMD_TRIG];
          rst_cmd_q <= wd_w[CMD_RESET];
        end
        if (awaddr_q == OFF_CTRL && wstrb_q[0])
        begin
          cont_q <= wd_w[CTRL_CONT];
          mon_q <= wd_w[CTRL_MON];
          ext_en_q <= wd_w[CTRL_EXT];
          auto_q <= wd_w[CTRL_AUTO];
          if (wd_w[CTRL_EXT])
            bp_en_q <= 1'b0;
        end
        if (awaddr_q == OFF_OUTST && wstrb_q[0])
        begin
          ext_en_q <= wd_w[0];
          if (wd_w[0])
            bp_en_q <= 1'b0;
        end
        if (awaddr_q == OFF_BPTRIG && wstrb_q[0])
        begin
          bp_sel_q <= wd_w[2:0];
          bp_en_q <= wd_w[BP_EN];
          if (wd_w[BP_EN])
            ext_en_q <= 1'b0;
        end
        if (awaddr_q == OFF_ARMCNT && wd_w[14:0] != 15'h0)
          armcnt_q <= wd_w[14:0];
        if (awaddr_q == OFF_CARD && card_ok(wd_w[6:0]))
          card_q <= wd_w[6:0];
        if (awaddr_q == OFF_LISTLEN)
          list_len_q <= wd_w[4:0];
        if (wr_list_w)
          list_q[awaddr_q[5:2]] <= wd_w[14:0];
        if (awaddr_q == OFF_IRQ_MASK)
          irq_mask_q <= wd_w[IRQ_W-1:0];
      end
      // The defaults command overrides writes in the same cycle to the fields it restores.
      if (rst_cmd_q)
      begin
        cont_q <= 1'b0;
        mon_q <= 1'b0;
        ext_en_q <= 1'b0;
        auto_q <= 1'b1;
        bp_en_q <= 1'b0;
        armcnt_q <= ARMCNT_RST;
      end
    end
  end

  // Scanner. One trigger is taken per settled closure; early triggers
  // during settling are dropped rather than queued.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= RSS_IDLE;
      closed_q <= 1'b0;
      list_idx_q <= 4'h0;
      cycles_q <= 15'h0;
      settle_cnt_q <= 8'h00;
      cur_card_q <= 7'h00;
      cur_row_q <= 4'h0;
      cur_col_q <= 4'h0;
      last_card_q <= 7'h00;
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      trig_meta_q <= trig_i;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
      if (rst_cmd_q)
      begin
        state_q <= RSS_IDLE;
        closed_q <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          RSS_IDLE:
            if (start_go_w)
            begin
              list_idx_q <= 4'h0;
              cycles_q <= armcnt_q;
              {cur_card_q, cur_row_q, cur_col_q} <= list_q[0];
              last_card_q <= list_q[0][14:8];
              closed_q <= 1'b1;
              settle_cnt_q <= 8'(SETTLE_CYC);
              state_q <= RSS_SETTLE;
            end
          RSS_SETTLE:
          begin
            settle_cnt_q <= settle_cnt_q - 8'h01;
            if (settle_done_w)
              state_q <= RSS_WAIT;
          end
          RSS_WAIT:
            if (advance_w)
            begin
              if (last_entry_w && !cont_q && cycles_q <= 15'h0001)
              begin
                closed_q <= 1'b0;
                state_q <= RSS_IDLE;
              end
              else
              begin
                list_idx_q <= last_entry_w ? 4'h0 : list_idx_q + 4'h1;
                if (last_entry_w && !cont_q)
                  cycles_q <= cycles_q - 15'h0001;
                {cur_card_q, cur_row_q, cur_col_q} <= next_entry_w;
                last_card_q <= next_entry_w[14:8];
                settle_cnt_q <= 8'(SETTLE_CYC);
                state_q <= RSS_SETTLE;
              end
            end
          default:
            state_q <= RSS_IDLE;
        endcase
      end
    end
  end

  // Trigger pulse and output stage. Pulses drive the line only while low,
  // so other modules sharing the line are not overridden.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pulse_cnt_q <= 8'h00;
      ext_trig_n_o <= 1'b1;
      ext_trig_oe_o <= 1'b0;
      bp_trig_n_o <= '1;
      bp_trig_oe_o <= '0;
      chan_closed_o <= 1'b0;
      chan_card_o <= 7'h00;
      chan_row_o <= 4'h0;
      chan_col_o <= 4'h0;
      mon_cnt_q <= 4'h0;
      mon_on_o <= 1'b0;
      mon_card_o <= 7'h00;
      mon_row_o <= 4'h0;
      mon_bits_o <= 16'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      if (settle_done_w && (ext_en_q || bp_en_q))
        pulse_cnt_q <= 8'(PULSE_CYC);
      else if (pulse_cnt_q != 8'h00)
        pulse_cnt_q <= pulse_cnt_q - 8'h01;
      ext_trig_n_o <= !(pulse_cnt_q != 8'h00 && ext_en_q);
      ext_trig_oe_o <= pulse_cnt_q != 8'h00 && ext_en_q;
      for (int i = 0; i < NUM_BP_LINES; i++)
      begin
        bp_trig_n_o[i] <= !(pulse_cnt_q != 8'h00 && bp_en_q &&
          bp_sel_q == 3'(i));
        bp_trig_oe_o[i] <= pulse_cnt_q != 8'h00 && bp_en_q &&
          bp_sel_q == 3'(i);
      end
      chan_closed_o <= closed_q;
      chan_card_o <= cur_card_q;
      chan_row_o <= cur_row_q;
      chan_col_o <= cur_col_q;
      mon_cnt_q <= mon_q ? mon_cnt_q + 4'h1 : 4'h0;
      mon_on_o <= mon_q;
      mon_card_o <= mon_card_w;
      mon_row_o <= mon_cnt_q;
      mon_bits_o <= mon_q ? row_bits(mon_cnt_q, closed_q, cur_card_q,
        mon_card_w, cur_row_q, cur_col_q) : 16'h0;
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_last_adv;
    (state_q == RSS_WAIT) && advance_w && last_entry_w && !rst_cmd_q;
  endsequence

  property p_mon_off;
    !mon_q |=> !mon_on_o && mon_bits_o == 16'h0;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("Monitor output active while monitor mode is off.");

  property p_mon_row;
    mon_q && closed_q && cur_card_q == mon_card_w && cur_row_q == mon_cnt_q
      |=> mon_bits_o == (16'h0001 << $past(cur_col_q)) &&
      mon_row_o == $past(mon_cnt_q);
  endproperty
  a_mon_row: assert property (p_mon_row)
    else $error("Monitor row bitmap does not show the closed crosspoint.");

  property p_start;
    start_go_w && !rst_cmd_q |=> closed_q && list_idx_q == 4'h0 &&
      state_q == RSS_SETTLE && {cur_card_q, cur_row_q, cur_col_q} == list_q[0];
  endproperty
  a_start: assert property (p_start)
    else $error("Start did not close the first list entry.");

  property p_wrap;
    s_last_adv ##0 cont_q |=> closed_q && list_idx_q == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Continuous scan did not wrap to the first entry.");

  property p_open;
    s_last_adv ##0 (!cont_q && cycles_q == 15'h0001) |=>
      !closed_q && state_q == RSS_IDLE ##1 !chan_closed_o;
  endproperty
  a_open: assert property (p_open)
    else $error("Last entry not opened at end of single scan.");

  property p_badlist;
    start_q && state_q == RSS_IDLE && !list_ok && !rst_cmd_q |=>
      state_q == RSS_IDLE && !closed_q && irq_stat_q[IRQ_ERR];
  endproperty
  a_badlist: assert property (p_badlist)
    else $error("Invalid list started a scan or raised no error.");

  property p_ext_pulse;
    settle_done_w && ext_en_q && !rst_cmd_q |=> ##1 (!ext_trig_n_o &&
      ext_trig_oe_o)[*2];
  endproperty
  a_ext_pulse: assert property (p_ext_pulse)
    else $error("No low trigger pulse after a settled closure.");

  property p_ext_quiet;
    !ext_en_q && !$past(ext_en_q) |-> ext_trig_n_o && !ext_trig_oe_o;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet)
    else $error("Disabled external trigger output was pulsed.");

  property p_one_output;
    !(ext_en_q && bp_en_q);
  endproperty
  a_one_output: assert property (p_one_output)
    else $error("External and backplane trigger outputs both enabled.");

endmodule // rss_core

`default_nettype wire

// [tb/rss_host.sv]
// Host model: an AXI4-Lite master that issues register commands.
// Assumes a slave on the same clock; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module rss_host
(
  input wire logic clk_i, // Clock
  output logic [7:0] s_axi_awaddr, // Write address
  output logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  output logic [31:0] s_axi_wdata, // Write data
  output logic [3:0] s_axi_wstrb, // Byte strobes
  output logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Response valid
  output logic s_axi_bready, // Response ready
  output logic [7:0] s_axi_araddr, // Read address
  output logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  output logic s_axi_rready // Read data ready
);
  logic hang = 1'b0;
  // Both ready lines stay high so no signal is driven twice in one step.
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0;
    s_axi_wdata = 32'h0;
  end
  task automatic put(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    r = s_axi_bresp;
    hang = hang | (n == 64);
  endtask
  task automatic get(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    hang = hang | (n == 64);
  endtask
endmodule // rss_host
`default_nettype wire

// [tb/relay_scan_sequencer_trigger_out_tb.sv]
// Testbench for the scan sequencer: registers, scans, triggers, interrupt.
// Assumes the host model as bus master and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module relay_scan_sequencer_trigger_out_tb;
  import rss_pkg::*;
  logic clk_i, resetn_i, trig_i, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic chan_closed_o, ext_trig_n_o, ext_trig_oe_o, mon_on_o, irq_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr, bp_trig_n_o, bp_trig_oe_o;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb, chan_row_o, chan_col_o, mon_row_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [6:0] chan_card_o, mon_card_o;
  logic [15:0] mon_bits_o;
  int bad_count = 0;
  int n_compared = 0;
  rss_core i_dut (.clk_i, .resetn_i, .trig_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .chan_closed_o, .chan_card_o, .chan_row_o, .chan_col_o, .ext_trig_n_o,
    .ext_trig_oe_o, .bp_trig_n_o, .bp_trig_oe_o, .mon_on_o, .mon_card_o,
    .mon_row_o, .mon_bits_o, .irq_o);
  rss_host i_host (.clk_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic to_fail();
    bad_count++;
    $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.put(a, d, rsp);
    if (i_host.hang)
      to_fail();
  endtask
  task automatic rd(input logic [7:0] a);
    i_host.get(a, rd_q, rsp);
    if (i_host.hang)
      to_fail();
  endtask
  // An open channel is waited for with c low; row and column then don't care.
  task automatic wait_cl(input logic c, input logic [3:0] r,
                         input logic [3:0] k);
    int n;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk_i);
      if (chan_closed_o === c && (!c || {chan_row_o, chan_col_o} === {r, k}))
        break;
    end
    if (n == 200)
      to_fail();
  endtask
  task automatic wait_pulse();
    int n;
    for (n = 0; n < 200 && ext_trig_n_o !== 1'b0; n++)
      @(posedge clk_i);
    if (n == 200)
      to_fail();
    chk(32'({ext_trig_oe_o, bp_trig_oe_o}), 32'h100);
  endtask
  task automatic wait_bp();
    int n;
    for (n = 0; n < 200 && bp_trig_n_o === 8'hff; n++)
      @(posedge clk_i);
    if (n == 200)
      to_fail();
    chk(32'({ext_trig_n_o, bp_trig_n_o, bp_trig_oe_o}), 32'h1df20);
  endtask
  // Triggering only after the pulse ends keeps two pulses from overlapping.
  task automatic pulse();
    int n;
    for (n = 0; n < 100 && (ext_trig_n_o !== 1'b1 ||
      bp_trig_n_o !== 8'hff); n++)
      @(posedge clk_i);
    if (n == 100)
      to_fail();
    trig_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig_i <= 1'b0;
  endtask
  task automatic t_reset();
    rd(OFF_CTRL);
    chk(rd_q, 32'h8);
    rd(OFF_ARMCNT);
    chk(rd_q, 32'h1);
    chk(32'({ext_trig_n_o, bp_trig_n_o, mon_on_o}), 32'h3fe);
    chk(32'({ext_trig_oe_o, bp_trig_oe_o}), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_regs();
    wr(OFF_CTRL, 32'h1);
    chk(32'(rsp), 32'(RESP_OKAY));
    rd(OFF_CTRL);
    chk(rd_q, 32'h1);
    wr(OFF_OUTST, 32'h1);
    rd(OFF_CTRL);
    chk(rd_q, 32'h5);
    wr(OFF_BPTRIG, 32'hf);
    rd(OFF_OUTST);
    chk(rd_q, 32'h0);
    wr(OFF_CTRL, 32'h4);
    rd(OFF_BPTRIG);
    chk(rd_q, 32'h7);
    rd(8'h28);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(OFF_MON_BASE, 32'h1);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(OFF_CARD, 32'h64);
    rd(OFF_CARD);
    chk(rd_q, 32'h1);
    $display("test registers done");
  endtask
  task automatic t_scan();
    int n;
    wr(OFF_LIST_BASE, 32'h0123);
    wr(OFF_LIST_BASE + 8'h4, 32'h015a);
    wr(OFF_LISTLEN, 32'h2);
    wr(OFF_CTRL, 32'h6);
    wr(OFF_CMD, 32'h1);
    wait_cl(1'b1, 4'h2, 4'h3);
    chk(32'(chan_card_o), 32'h1);
    wait_pulse();
    for (n = 0; n < 20 && mon_row_o !== 4'h2; n++)
      @(posedge clk_i);
    chk(32'({mon_on_o, mon_bits_o}), 32'h10008);
    chk(32'(mon_card_o), 32'h1);
    pulse();
    wait_cl(1'b1, 4'h5, 4'ha);
    wait_pulse();
    pulse();
    wait_cl(1'b0, 4'h0, 4'h0);
    rd(OFF_IRQ_STAT);
    chk(32'(rd_q[IRQ_DONE]), 32'h1);
    $display("test single scan done");
  endtask
  task automatic t_cont();
    wr(OFF_CTRL, 32'h1);
    wr(OFF_BPTRIG, 32'hd);
    wr(OFF_CMD, 32'h1);
    wait_cl(1'b1, 4'h2, 4'h3);
    wait_bp();
    pulse();
    wait_cl(1'b1, 4'h5, 4'ha);
    // Hand over to the external output before this closure settles.
    wr(OFF_OUTST, 32'h1);
    rd(OFF_BPTRIG);
    chk(rd_q, 32'h5);
    wait_pulse();
    pulse();
    wait_cl(1'b1, 4'h2, 4'h3);
    wr(OFF_CMD, 32'h4);
    rd(OFF_CTRL);
    chk(rd_q, 32'h8);
    $display("test continuous scan done");
  endtask
  task automatic t_err();
    wr(OFF_IRQ_STAT, 32'h7);
    wr(OFF_IRQ_MASK, 32'h4);
    wr(OFF_LISTLEN, 32'h0);
    wr(OFF_CMD, 32'h1);
    rd(OFF_STATUS);
    chk(rd_q, 32'h0);
    rd(OFF_IRQ_STAT);
    chk(rd_q, 32'h4);
    chk(32'({chan_closed_o, irq_o}), 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    rd(OFF_IRQ_STAT);
    chk(32'(irq_o), 32'h0);
    wr(OFF_IRQ_STAT, 32'h4);
    rd(OFF_IRQ_STAT);
    chk(rd_q, 32'h0);
    $display("test list error done");
  endtask
  initial
  begin
    resetn_i = 1'b0;
    trig_i = 1'b0;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_regs();
    t_scan();
    t_cont();
    t_err();
    final_report();
  end
endmodule // relay_scan_sequencer_trigger_out_tb
`default_nettype wire
